/* File: dma_host_model.sv */
// host-side dma acceptor model for the streaming read command
`timescale 1ns/1ps
`default_nettype none
module dma_host_model (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // dma handshake
    input  wire logic        dmaReq,
    output var  logic        dmaAck,
    input  wire logic [47:0] xferLba,
    // bench control and observation
    input  wire logic        stall,
    input  wire logic        arm,
    output var  logic [31:0] beats,
    output var  logic [47:0] firstLba
);
    logic armed;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dmaAck   <= 1'b0;
            beats    <= 32'h0;
            firstLba <= 48'h0;
            armed    <= 1'b0;
        end else begin
            // ack only while the device asks and we are not stalling
            dmaAck <= dmaReq && !stall;
            if (arm) begin
                armed <= 1'b1;
            end
            if (dmaReq && dmaAck) begin
                beats <= beats + 32'h1;
                if (armed) begin
                    firstLba <= xferLba;
                    armed    <= 1'b0;
                end
            end
        end
    end
endmodule : dma_host_model
`default_nettype wire

/* File: stream_dma_read_command.sv */
// device-side streaming dma read command interpreter with apb registers
`timescale 1ns/1ps
`default_nettype none
`include "stream_read_params.svh"

module stream_dma_read_command #(
    parameter int STREAMS = 8
) (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    // media side
    input  wire logic        sectorDone,
    input  wire stream_read_pkg::media_err_t mediaErr,
    input  wire logic        deferredWriteErr,
    // dma handshake
    output var  logic        dmaReq,
    input  wire logic        dmaAck,
    output var  logic [47:0] xferLba,
    // interrupt
    output var  logic        intrq
);
    if (STREAMS != 8) begin : g_bad_streams
        $error("stream_dma_read_command: three-bit stream id needs 8 streams");
    end

    ////////////////////////////////////////////////////////////////////////
    stream_read_pkg::state_t state_q, state_d;
    stream_read_pkg::feat_t  feat_q;
    logic [15:0] cntCur_q, cntPrev_q;
    logic [23:0] lbaCur_q, lbaPrev_q;
    logic [16:0] remain_q;
    logic [47:0] lba_q;
    logic [47:0] failLba_q;
    logic [16:0] failCnt_q;
    logic        failSeen_q;
    logic [7:0]  status_q, error_q;
    logic [7:0]  errLog_q;
    logic [15:0] timeUnit_q;
    logic [7:0]  defLimit_q [STREAMS];
    logic [47:0] lastErrLba_q [STREAMS];
    logic [31:0] usLeft_q;
    logic [7:0]  cycCnt_q;
    logic        limitOn_q;
    logic        hob_q;
    logic [2:0]  irqStat_q, irqMask_q;
    logic        deferSeen_q;

    function automatic logic [16:0] sectorsOf(input logic [15:0] c);
        sectorsOf = (c == 16'h0000) ? 17'h10000 : {1'b0, c};
    endfunction : sectorsOf

    wire acc      = psel && penable;
    wire wrEn     = acc && pwrite;
    wire cmdWrite = wrEn && (paddr == `REG_CTRL) && pwdata[0] && (state_q == stream_read_pkg::S_IDLE);
    wire hobWrite = wrEn && (paddr == `REG_CTRL);
    wire [7:0]  selDef = defLimit_q[feat_q.streamId];
    wire [7:0]  limByte = (feat_q.limit != 8'h00) ? feat_q.limit : selDef;
    wire [15:0] limStart = {8'h00, limByte};
    wire [31:0] budget = limStart * timeUnit_q;
    wire        tick = (cycCnt_q == 8'(`CYC_PER_US - 1));
    wire        expired = limitOn_q && (usLeft_q == 32'h0);
    wire        beat = dmaReq && dmaAck;
    wire        lastBeat = beat && (remain_q == 17'h1);
    wire        hardErr = mediaErr.valid && !feat_q.cont;
    wire        softErr = mediaErr.valid && feat_q.cont;

    ////////////////////////////////////////////////////////////////////////
    // command sequencer
    always_comb begin
        state_d = state_q;
        case (state_q)
            stream_read_pkg::S_IDLE: if (cmdWrite) state_d = stream_read_pkg::S_XFER;
            stream_read_pkg::S_XFER: if (lastBeat || hardErr || expired) state_d = stream_read_pkg::S_DONE;
            stream_read_pkg::S_DONE: state_d = stream_read_pkg::S_IDLE;
            default: state_d = stream_read_pkg::S_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q <= stream_read_pkg::S_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // task file loads: previous byte is the older write
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cntCur_q  <= 16'h0;
            cntPrev_q <= 16'h0;
            lbaCur_q  <= 24'h0;
            lbaPrev_q <= 24'h0;
            feat_q    <= '0;
        end else if (wrEn && state_q == stream_read_pkg::S_IDLE) begin
            if (paddr == `REG_COUNT) begin
                cntPrev_q <= cntCur_q;
                cntCur_q  <= pwdata[15:0];
            end else if (paddr == `REG_LBA_LO) begin
                lbaPrev_q <= lbaCur_q;
                lbaCur_q  <= pwdata[23:0];
            end else if (paddr == `REG_FEAT) begin
                feat_q <= stream_read_pkg::feat_t'({pwdata[7:4], pwdata[2:0], pwdata[15:8]});
            end
        end
    end

    // transfer engine
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            remain_q <= 17'h0;
            lba_q    <= 48'h0;
            dmaReq   <= 1'b0;
            xferLba  <= 48'h0;
        end else begin
            if (cmdWrite) begin
                remain_q <= sectorsOf({cntPrev_q[7:0], cntCur_q[7:0]});
                lba_q    <= feat_q.resume ? lastErrLba_q[feat_q.streamId]
                          : {lbaPrev_q[23:16], lbaPrev_q[15:8], lbaPrev_q[7:0],
                             lbaCur_q[23:16], lbaCur_q[15:8], lbaCur_q[7:0]};
                dmaReq   <= 1'b0;
            end else if (state_q == stream_read_pkg::S_XFER) begin
                dmaReq <= !(lastBeat || hardErr || expired);
                if (beat) begin
                    remain_q <= remain_q - 17'h1;
                    lba_q    <= lba_q + 48'h1;
                end
            end else begin
                dmaReq <= 1'b0;
            end
            xferLba <= lba_q;
        end
    end

    // completion time budget counter
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            usLeft_q  <= 32'h0;
            cycCnt_q  <= 8'h0;
            limitOn_q <= 1'b0;
        end else if (cmdWrite) begin
            usLeft_q  <= budget;
            cycCnt_q  <= 8'h0;
            limitOn_q <= (budget != 32'h0);
        end else if (state_q == stream_read_pkg::S_XFER && limitOn_q) begin
            cycCnt_q <= tick ? 8'h0 : cycCnt_q + 8'h1;
            if (tick && usLeft_q != 32'h0) usLeft_q <= usLeft_q - 32'h1;
        end else if (state_q != stream_read_pkg::S_XFER) begin
            limitOn_q <= 1'b0;
        end
    end

    // error capture and ending status
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            failLba_q   <= 48'h0;
            failCnt_q   <= 17'h0;
            failSeen_q  <= 1'b0;
            status_q    <= 8'h40;
            error_q     <= 8'h0;
            errLog_q    <= 8'h0;
            deferSeen_q <= 1'b0;
            for (int i = 0; i < STREAMS; i++) lastErrLba_q[i] <= 48'h0;
        end else begin
            if (deferredWriteErr) deferSeen_q <= 1'b1;
            if (cmdWrite) begin
                failSeen_q <= 1'b0;
                failCnt_q  <= 17'h0;
                error_q    <= 8'h0;
                errLog_q   <= 8'h0;
                status_q   <= 8'h80;
            end else if (state_q == stream_read_pkg::S_XFER) begin
                status_q[`ST_DRQ] <= dmaReq;
                if (mediaErr.valid) begin
                    if (!failSeen_q) begin
                        failLba_q  <= lba_q;
                        failSeen_q <= 1'b1;
                        lastErrLba_q[feat_q.streamId] <= lba_q;
                    end
                    failCnt_q <= failCnt_q + 17'h1;
                    if (softErr) begin
                        errLog_q <= errLog_q | {mediaErr.crc, mediaErr.unc, 1'b0, mediaErr.idn,
                                                1'b0, mediaErr.abt, 2'b00};
                    end else begin
                        error_q <= {mediaErr.crc, mediaErr.unc, 1'b0, mediaErr.idn,
                                    1'b0, mediaErr.abt, 2'b00};
                    end
                end
                if (expired) begin
                    if (feat_q.cont) errLog_q[`ER_TIMEOUT] <= 1'b1;
                    else error_q[`ER_TIMEOUT] <= 1'b1;
                end
            end else if (state_q == stream_read_pkg::S_DONE) begin
                status_q[`ST_BUSY]       <= 1'b0;
                status_q[`ST_DRQ]        <= 1'b0;
                status_q[`ST_READY]      <= 1'b1;
                status_q[`ST_STREAM_ERR] <= feat_q.cont && (failSeen_q || errLog_q != 8'h0);
                status_q[`ST_ERR]        <= !feat_q.cont && (error_q != 8'h0);
                status_q[`ST_DEFER_ERR]  <= deferSeen_q || deferredWriteErr;
                if (deferSeen_q || deferredWriteErr) deferSeen_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration and interrupt registers
    wire [2:0] irqEvt = {expired && state_q == stream_read_pkg::S_XFER,
                         mediaErr.valid && state_q == stream_read_pkg::S_XFER,
                         state_q == stream_read_pkg::S_DONE};
    wire [2:0] irqClr = (wrEn && paddr == `REG_IRQ_STAT) ? pwdata[2:0] : 3'b000;
    wire [2:0] irqMaskNext = (wrEn && paddr == `REG_IRQ_MASK) ? pwdata[2:0] : irqMask_q;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            timeUnit_q <= `TIMEUNIT_RST;
            irqStat_q  <= 3'b000;
            irqMask_q  <= 3'b000;
            hob_q      <= 1'b0;
            intrq      <= 1'b0;
            for (int i = 0; i < STREAMS; i++) defLimit_q[i] <= 8'h00;
        end else begin
            irqStat_q <= (irqStat_q & ~irqClr) | irqEvt; // set wins
            intrq     <= |(((irqStat_q & ~irqClr) | irqEvt) & irqMaskNext);
            irqMask_q <= irqMaskNext;
            if (hobWrite) hob_q <= pwdata[7];
            if (wrEn && paddr == `REG_TIMEUNIT) timeUnit_q <= pwdata[15:0];
            if (wrEn && paddr == `REG_DEFLIMIT) defLimit_q[pwdata[10:8]] <= pwdata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb read path
    wire [47:0] repLba = failSeen_q ? failLba_q : lba_q;
    wire [15:0] repCnt = feat_q.cont ? failCnt_q[15:0] : remain_q[15:0];
    wire        known = (paddr <= `REG_ERRLOG) && (paddr[1:0] == 2'b00);
    logic [31:0] rdMux;
    always_comb begin
        rdMux = 32'h0;
        if (paddr == `REG_CTRL) rdMux = {24'h0, hob_q, 7'h0};
        else if (paddr == `REG_FEAT) rdMux = {16'h0, feat_q.limit, feat_q.urgent, feat_q.cont,
                                              feat_q.notSeq, feat_q.resume, 1'b0, feat_q.streamId};
        else if (paddr == `REG_COUNT) rdMux = {16'h0, cntCur_q};
        else if (paddr == `REG_LBA_LO) rdMux = {8'h0, lbaCur_q};
        else if (paddr == `REG_LBA_HI) rdMux = {8'h0, lbaPrev_q};
        else if (paddr == `REG_STATUS) rdMux = {24'h0, status_q};
        else if (paddr == `REG_ERROR) rdMux = {24'h0, error_q};
        else if (paddr == `REG_FAIL_LO) rdMux = hob_q ? {8'h0, repLba[47:24]} : {8'h0, repLba[23:0]};
        else if (paddr == `REG_FAIL_HI) rdMux = {16'h0, repLba[47:32]};
        else if (paddr == `REG_FAIL_CNT) rdMux = {24'h0, hob_q ? repCnt[15:8] : repCnt[7:0]};
        else if (paddr == `REG_TIMEUNIT) rdMux = {16'h0, timeUnit_q};
        else if (paddr == `REG_IRQ_STAT) rdMux = {29'h0, irqStat_q};
        else if (paddr == `REG_IRQ_MASK) rdMux = {29'h0, irqMask_q};
        else if (paddr == `REG_ERRLOG) rdMux = {24'h0, errLog_q};
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !known;
            prdata  <= (psel && !penable && !pwrite) ? rdMux : 32'h0;
        end
    end
endmodule : stream_dma_read_command
`default_nettype wire

/* File: stream_dma_read_command_chk.sv */
// port-level assertions for the streaming dma read command interpreter
`timescale 1ns/1ps
`default_nettype none
`include "stream_read_params.svh"
module stream_dma_read_command_chk #(
    parameter int STREAMS = 8
) (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    // media side
    input  wire logic        sectorDone,
    input  wire stream_read_pkg::media_err_t mediaErr,
    input  wire logic        deferredWriteErr,
    // dma handshake
    input  wire logic        dmaReq,
    input  wire logic        dmaAck,
    input  wire logic [47:0] xferLba,
    // interrupt
    input  wire logic        intrq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    AST_SETUP_READY: assert property (psel && !penable |=> pready && penable)
        else $error("setup cycle not answered in first access cycle");
    AST_READY_ONE: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready && psel && penable)
        else $error("pslverr outside an access phase");
    AST_UNMAPPED: assert property (psel && !penable && (paddr > 12'h038 || paddr[1:0] != 2'b00) |=> pslverr)
        else $error("unmapped access not refused");
    AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0)
        else $error("read data not zero outside answer");
    AST_MASK_OFF: assert property (psel && penable && pwrite && paddr == `REG_IRQ_MASK
        && pwdata[2:0] == 3'b000 |=> !intrq)
        else $error("interrupt stays up with all events masked");
    AST_LBA_STEP: assert property (dmaReq && dmaAck |-> ##2 xferLba == $past(xferLba) + 48'h1)
        else $error("transfer address did not advance one sector per beat");
    AST_RESET_IDLE: assert property ($fell(rst) |-> !dmaReq && !intrq && xferLba == 48'h0)
        else $error("dma or interrupt active right after reset");

    cover property (dmaReq && dmaAck);
    cover property (pslverr);
    cover property ($rose(intrq));
endmodule : stream_dma_read_command_chk

bind stream_dma_read_command stream_dma_read_command_chk #(.STREAMS(STREAMS)) u_chk (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sectorDone(sectorDone),
    .mediaErr(mediaErr), .deferredWriteErr(deferredWriteErr), .dmaReq(dmaReq), .dmaAck(dmaAck),
    .xferLba(xferLba), .intrq(intrq));
`default_nettype wire

/* File: stream_dma_read_command_tb.sv */
// self-checking bench for the streaming dma read command interpreter
`timescale 1ns/1ps
`default_nettype none
`include "stream_read_params.svh"
module stream_dma_read_command_tb;
    localparam logic [47:0] LA = 48'h1234_5678_9abc;
    localparam logic [47:0] LB = 48'h0a0b_0c0d_0e0f;
    logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr, err;
    logic        dmaReq, dmaAck, intrq, stall, arm, deferredWriteErr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, beats, b0;
    logic [47:0] xferLba, firstLba;
    stream_read_pkg::media_err_t mediaErr;
    int          n_mismatch, checks_done, cycles;

    stream_dma_read_command #(.STREAMS(8)) uut (
        .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sectorDone(1'b0),
        .mediaErr(mediaErr), .deferredWriteErr(deferredWriteErr), .dmaReq(dmaReq), .dmaAck(dmaAck),
        .xferLba(xferLba), .intrq(intrq));
    dma_host_model host (
        .ref_clk(ref_clk), .rst(rst), .dmaReq(dmaReq), .dmaAck(dmaAck), .xferLba(xferLba),
        .stall(stall), .arm(arm), .beats(beats), .firstLba(firstLba));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            test_done();
        end
    end

    task automatic test_done();
        if (n_mismatch == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done

    task automatic chk(input logic [47:0] got, input logic [47:0] exp, input logic [47:0] m);
        checks_done++;
        if ((got & m) !== (exp & m)) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask : apb

    task automatic rdc(input logic [11:0] a, input logic [47:0] exp, input logic [47:0] m);
        apb(a, 1'b0, 32'h0);
        chk({16'h0, rd}, exp, m);
    endtask : rdc

    task automatic cmd(input logic [15:0] f, input logic [15:0] n, input logic [47:0] l);
        apb(`REG_FEAT, 1'b1, {16'h0, f});
        apb(`REG_COUNT, 1'b1, {24'h0, n[15:8]});
        apb(`REG_COUNT, 1'b1, {24'h0, n[7:0]});
        apb(`REG_LBA_LO, 1'b1, {8'h0, l[47:24]});
        apb(`REG_LBA_LO, 1'b1, {8'h0, l[23:0]});
        b0 = beats;
        arm <= 1'b1;
        apb(`REG_CTRL, 1'b1, 32'h1);
        arm <= 1'b0;
    endtask : cmd

    task automatic finish();
        int k;
        k = 0;
        do begin
            apb(`REG_STATUS, 1'b0, 32'h0);
            k++;
        end while (rd[`ST_BUSY] !== 1'b0 && k < 400);
    endtask : finish

    task automatic media(input logic [4:0] e);
        mediaErr <= e;
        @(posedge ref_clk);
        mediaErr <= 5'h00;
    endtask : media

    initial begin
        int k;
        rst = 1'b1;
        {psel, penable, pwrite, stall, arm, deferredWriteErr} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        mediaErr = 5'h00;
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        rdc(`REG_STATUS, 48'h40, 48'hff);
        apb(12'h03c, 1'b0, 32'h0);
        chk({47'h0, err}, 48'h1, 48'h1);
        apb(`REG_IRQ_MASK, 1'b1, 32'h7);
        //////////////////////////////////////////////////////////////////////
        // 256 sectors from the high count byte alone
        cmd(16'h0002, 16'h0100, LA);
        finish();
        chk({16'h0, rd}, 48'h40, 48'hff);
        chk({16'h0, beats - b0}, 48'd256, 48'hffffffff);
        chk(firstLba, LA, '1);
        chk({47'h0, intrq}, 48'h1, 48'h1);
        apb(`REG_IRQ_STAT, 1'b1, 32'h7);
        rdc(`REG_IRQ_STAT, 48'h0, 48'h7);
        chk({47'h0, intrq}, 48'h0, 48'h1);
        //////////////////////////////////////////////////////////////////////
        // hard error in ordinary mode, interrupt masked
        apb(`REG_IRQ_MASK, 1'b1, 32'h0);
        stall <= 1'b1;
        cmd(16'h0002, 16'h0003, LB);
        media(5'b10100);
        finish();
        chk({16'h0, rd}, 48'h41, 48'hff);
        rdc(`REG_ERROR, 48'h40, 48'hd5);
        rdc(`REG_FAIL_LO, {24'h0, LB[23:0]}, 48'hffffff);
        rdc(`REG_FAIL_CNT, 48'h3, 48'hff);
        apb(`REG_CTRL, 1'b1, 32'h80);
        rdc(`REG_FAIL_LO, {24'h0, LB[47:24]}, 48'hffffff);
        apb(`REG_CTRL, 1'b1, 32'h0);
        chk({47'h0, intrq}, 48'h0, 48'h1);
        rdc(`REG_IRQ_STAT, 48'h3, 48'h3);
        apb(`REG_IRQ_MASK, 1'b1, 32'h7);
        rdc(`REG_IRQ_STAT, 48'h3, 48'h3);
        chk({47'h0, intrq}, 48'h1, 48'h1);
        apb(`REG_IRQ_MASK, 1'b1, 32'h0);
        chk({47'h0, intrq}, 48'h0, 48'h1);
        apb(`REG_IRQ_MASK, 1'b1, 32'h7);
        apb(`REG_IRQ_STAT, 1'b1, 32'h7);
        stall <= 1'b0;
        //////////////////////////////////////////////////////////////////////
        // resume at the last error of stream 2, then continuous read with error
        cmd(16'h0012, 16'h0001, LA);
        finish();
        chk(firstLba, LB, '1);
        stall <= 1'b1;
        cmd(16'h0041, 16'h0003, LA);
        media(5'b11000);
        stall <= 1'b0;
        finish();
        chk({16'h0, rd}, 48'h60, 48'hff);
        chk({16'h0, beats - b0}, 48'd3, 48'hffffffff);
        rdc(`REG_ERROR, 48'h0, 48'hd5);
        rdc(`REG_ERRLOG, 48'h80, 48'h80);
        rdc(`REG_FAIL_LO, {24'h0, LA[23:0]}, 48'hffffff);
        rdc(`REG_FAIL_CNT, 48'h1, 48'hff);
        apb(`REG_IRQ_STAT, 1'b1, 32'h7);
        //////////////////////////////////////////////////////////////////////
        // time limit: explicit byte in continuous mode, stream default when urgent
        apb(`REG_DEFLIMIT, 1'b1, 32'h0000_0301);
        stall <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            cmd(i ? 16'h0083 : 16'h0140, 16'h0005, LA);
            k = 1;
            while (intrq !== 1'b1 && k < 300) begin
                @(posedge ref_clk);
                k++;
            end
            chk({47'h0, k > 98 && k < 106}, 48'h1, 48'h1);
            finish();
            chk({16'h0, rd}, i ? 48'h41 : 48'h60, 48'hff);
            rdc(i ? `REG_ERROR : `REG_ERRLOG, 48'h1, 48'h1);
            apb(`REG_IRQ_STAT, 1'b1, 32'h7);
        end
        // no byte and no default: no limit applies
        cmd(16'h0004, 16'h0002, LA);
        repeat (300) @(posedge ref_clk);
        rdc(`REG_STATUS, 48'h80, 48'h80);
        stall <= 1'b0;
        finish();
        chk({16'h0, rd}, 48'h40, 48'hff);
        //////////////////////////////////////////////////////////////////////
        // deferred write error reported in status
        deferredWriteErr <= 1'b1;
        @(posedge ref_clk);
        deferredWriteErr <= 1'b0;
        cmd(16'h0020, 16'h0001, LA);
        finish();
        chk({16'h0, rd}, 48'h50, 48'hff);
        rdc(`REG_FEAT, 48'h20, 48'hff);
        test_done();
    end
endmodule : stream_dma_read_command_tb
`default_nettype wire

/* File: stream_read_params.svh */
// constants for the streaming dma read command interpreter
`ifndef STREAM_READ_PARAMS_SVH
`define STREAM_READ_PARAMS_SVH
// apb register byte offsets
`define REG_CTRL        12'h000
`define REG_FEAT        12'h004
`define REG_COUNT       12'h008
`define REG_LBA_LO      12'h00c
`define REG_LBA_HI      12'h010
`define REG_STATUS      12'h014
`define REG_ERROR       12'h018
`define REG_FAIL_LO     12'h01c
`define REG_FAIL_HI     12'h020
`define REG_FAIL_CNT    12'h024
`define REG_TIMEUNIT    12'h028
`define REG_DEFLIMIT    12'h02c
`define REG_IRQ_STAT    12'h030
`define REG_IRQ_MASK    12'h034
`define REG_ERRLOG      12'h038
// feature byte fields
`define FEAT_URGENT     7
`define FEAT_CONT       6
`define FEAT_NOTSEQ     5
`define FEAT_RESUME     4
`define FEAT_SID_HI     2
// status bits
`define ST_BUSY         7
`define ST_READY        6
`define ST_STREAM_ERR   5
`define ST_DEFER_ERR    4
`define ST_DRQ          3
`define ST_ERR          0
// error register bits
`define ER_CRC          7
`define ER_UNC          6
`define ER_IDN          4
`define ER_ABT          2
`define ER_TIMEOUT      0
// timing: one microsecond of reference clock
`define CLK_MHZ         100
`define US_NS           1000
`define CLK_NS          10
`define CYC_PER_US      (`US_NS / `CLK_NS)
`define TIMEUNIT_RST    16'h0001
`endif

/* File: stream_read_pkg.sv */
// types for the streaming dma read command interpreter
package stream_read_pkg;
    typedef struct packed {
        logic [31:0] addr;
        logic        write;
        logic [31:0] wdata;
    } apb_req_t;
    typedef struct packed {
        logic        urgent;
        logic        cont;
        logic        notSeq;
        logic        resume;
        logic [2:0]  streamId;
        logic [7:0]  limit;
    } feat_t;
    typedef struct packed {
        logic        valid;
        logic        crc;
        logic        unc;
        logic        idn;
        logic        abt;
    } media_err_t;
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_XFER = 3'b001,
        S_DONE = 3'b010
    } state_t;
endpackage : stream_read_pkg
